// >>> bench/lgcp_host_model.sv
// host processor model driving the parallel register port
`timescale 1ns/100ps
module lgcp_host_model (
  input wire logic clk_i,
  input wire logic oe_i,
  input wire logic [7:0] rdata_i,
  output logic cs_b_o,
  output logic wr_b_o,
  output logic rd_b_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o
);
  logic oe_seen = 1'b0;
  initial begin
    cs_b_o = 1'b1;
    wr_b_o = 1'b1;
    rd_b_o = 1'b1;
    addr_o = 7'h00;
    wdata_o = 8'h00;
  end
  // released lines show inverted values, never a stale copy
  task automatic release_bus;
    cs_b_o <= 1'b1;
    wr_b_o <= 1'b1;
    rd_b_o <= 1'b1;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cs_b_o <= 1'b0;
    wr_b_o <= 1'b0;
    addr_o <= a;
    wdata_o <= d & ((a == 7'h40) ? 8'hfb : 8'h7f);
    @(posedge clk_i);
    release_bus();
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    cs_b_o <= 1'b0;
    rd_b_o <= 1'b0;
    addr_o <= a;
    @(posedge clk_i);
    oe_seen = oe_i;
    release_bus();
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

// >>> bench/lgcp_top_test.sv
// self-checking bench for line control and segment 8 registers
`timescale 1ns/100ps
module lgcp_top_test;
  import lgcp_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cs_b, wr_b, rd_b, oe, arb = 1'b0, tick = 1'b0;
  logic [6:0] addr;
  logic [7:0] wd, rdat, d;
  logic [3:0] tclk = '0, tp = '0, tn = '0, los = '0, rck = '0, rxd = '0;
  logic [3:0] irq_req = '0, sgn, txp, txn, rxo, irq;
  logic [23:0] mag;
  logic srail, srst, srst_long;
  logic [6:0] ofs [5] = '{SEG8_CH0_OFS, SEG8_CH1_OFS, SEG8_CH2_OFS,
    SEG8_CH3_OFS, GLOBAL_CTRL_OFS};
  int miscompares = 0;
  int checks = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  lgcp_host_model h (.clk_i(core_clk_i), .oe_i(oe),
    .rdata_i(rdat), .cs_b_o(cs_b), .wr_b_o(wr_b), .rd_b_o(rd_b),
    .addr_o(addr), .wdata_o(wd));
  lgcp_top #(.NCH(4)) u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .host_cs_b_i(cs_b), .host_wr_b_i(wr_b), .host_rd_b_i(rd_b),
    .host_addr_i(addr), .host_data_i(wd), .host_data_o(rdat),
    .host_data_oe_o(oe), .arb_mode_i(arb), .seg_tick_i(tick),
    .seg8_sign_o(sgn), .seg8_mag_o(mag), .channel_transmit_clock_i(tclk),
    .transmit_positive_data_i(tp), .transmit_negative_data_i(tn),
    .receive_signal_loss_i(los), .tx_pos_o(txp), .tx_neg_o(txn),
    .rx_clk_i(rck), .rx_data_i(rxd), .rx_data_o(rxo),
    .chan_irq_req_i(irq_req), .chan_irq_o(irq), .single_rail_o(srail),
    .soft_reset_o(srst), .soft_reset_long_o(srst_long));
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_regs;
    foreach (ofs[i]) begin
      h.rd(ofs[i], d);
      chk(d, 8'h00, "reset value");
    end
    chk(h.oe_seen, 1'b1, "read drives bus");
    chk(oe, 1'b0, "bus released");
    h.rd(7'h0e, d);
    chk(d, 8'h00, "unmapped read");
    for (int i = 0; i < 4; i++) h.wr(ofs[i], 8'hc1 + i);
    for (int i = 0; i < 4; i++) begin
      h.rd(ofs[i], d);
      chk(d, 8'h41 + i, "segment readback");
    end
    $display("regs done");
  endtask
  // outputs are read one edge after the edge that launches them
  task automatic t_pulse;
    arb <= 1'b1;
    cyc(2);
    for (int k = 1; k <= 8; k++) begin
      tick <= 1'b1;
      cyc(1);
      tick <= 1'b0;
      cyc(2);
      chk(sgn, (k == 7) ? 4'hf : 4'h0, "seg8 sign");
      chk(mag, (k == 7) ? 24'h103081 : 24'h0, "seg8 mag");
    end
    arb <= 1'b0;
    $display("pulse done");
  endtask
  task automatic t_data;
    logic [1:0] p [2];
    rxd <= 4'h5;
    tp <= 4'h6;
    tn <= 4'h9;
    tclk <= 4'hf;
    cyc(3);
    rck <= 4'hf;
    tclk <= 4'h0;
    cyc(4);
    chk(rxo, 4'h5, "rx rising edge");
    chk({txp, txn}, 8'h69, "tx falling edge");
    rxd <= 4'h3;
    cyc(4);
    chk(rxo, 4'h5, "rx no edge");
    h.wr(GLOBAL_CTRL_OFS, 8'hf8);
    los <= 4'h1;
    rck <= 4'h0;
    tclk <= 4'hf;
    cyc(4);
    chk(rxo, 4'hc, "rx falling inverted");
    chk({txp, txn, srail}, 9'h12d, "all ones single rail");
    h.wr(GLOBAL_CTRL_OFS, 8'h00);
    cyc(1);
    chk(srail, 1'b0, "dual rail");
    h.wr(GLOBAL_CTRL_OFS, 8'h50);
    for (int k = 0; k < 2; k++) begin
      tclk <= 4'h0;
      cyc(2);
      tclk <= 4'hf;
      cyc(2);
      p[k] = {txp[0], txn[0]};
      chk(^p[k], 1'b1, "dual rail one rail");
    end
    chk(p[0] ^ p[1], 2'h3, "dual rail alternates");
    $display("data done");
  endtask
  task automatic t_irq_srst;
    irq_req <= 4'ha;
    h.wr(GLOBAL_CTRL_OFS, 8'h02);
    cyc(2);
    chk(irq, 4'ha, "irq enabled");
    h.wr(GLOBAL_CTRL_OFS, 8'h00);
    cyc(2);
    chk(irq, 4'h0, "irq masked");
    h.wr(GLOBAL_CTRL_OFS, 8'h03);
    cyc(2);
    chk({irq, srst, srst_long}, 6'h02, "soft reset start");
    cyc(2010);
    chk(srst_long, 1'b1, "soft reset held");
    h.rd(SEG8_CH2_OFS, d);
    chk(d, 8'h43, "register kept");
    h.wr(GLOBAL_CTRL_OFS, 8'h00);
    cyc(2);
    chk(srst, 1'b0, "soft reset end");
    $display("irq and soft reset done");
  endtask
  initial begin
    cyc(20000);
    miscompares++;
    finish_test();
  end
  initial begin
    cyc(3);
    rst_b_i <= 1'b1;
    t_regs();
    t_pulse();
    t_data();
    t_irq_srst();
    finish_test();
  end
endmodule

// >>> rtl/lgcp_pkg.sv
// constants for the line config and pulse segment 8 register bank
package lgcp_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 4;
  localparam int AMP_W = 7;
  localparam int SEG_W = 3;
  localparam logic [ADDR_W-1:0] SEG8_CH0_OFS = 7'h0f;
  localparam logic [ADDR_W-1:0] SEG8_CH1_OFS = 7'h1f;
  localparam logic [ADDR_W-1:0] SEG8_CH2_OFS = 7'h2f;
  localparam logic [ADDR_W-1:0] SEG8_CH3_OFS = 7'h3f;
  localparam logic [ADDR_W-1:0] GLOBAL_CTRL_OFS = 7'h40;
  localparam logic [1:0] CH_FIELD_LSB = 2'h0;
  localparam logic [3:0] SEG8_LOW_NIBBLE = 4'hf;
  localparam logic [AMP_W-1:0] SEG8_RESET = 7'h00;
  localparam logic [DATA_W-1:0] GLOBAL_RESET = 8'h00;
  localparam int AMP_SIGN_BIT = 6;
  localparam int RAIL_BIT = 7;
  localparam int AUTO_ONES_BIT = 6;
  localparam int RX_EDGE_BIT = 5;
  localparam int TX_EDGE_BIT = 4;
  localparam int POL_BIT = 3;
  localparam int RSVD_BIT = 2;
  localparam int IRQ_EN_BIT = 1;
  localparam int SRST_BIT = 0;
  localparam logic [SEG_W-1:0] SEG8_INDEX = 3'h7;
  localparam int CLK_MHZ = 200;
  localparam int SRST_MIN_US = 10;
  localparam int SRST_CYC = SRST_MIN_US * CLK_MHZ;
  localparam int SRST_CNT_W = 12;
endpackage

// >>> rtl/lgcp_top.sv
// global line control and per-channel pulse segment 8 registers
//
// How it works
// - segment 8 amplitude is sign-magnitude, bit6 sign
// - eighth pulse segment driven with stored amplitude
// - four independent per-channel segment 8 registers
// - rail format bit: one single, zero dual
// - auto ones sent on receive signal loss
// - receive edge bit: one falling, zero rising
// - transmit edge bit: zero falling, one rising
// - polarity bit: zero active high, one low, except for auto ones
// - channel interrupts pass only when enable set
// - soft reset bit holds internal circuits reset
// - soft reset leaves host registers untouched
`timescale 1ns/100ps
module lgcp_top #(
  parameter int NCH = lgcp_pkg::NUM_CH
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic host_cs_b_i,
  input wire logic host_wr_b_i,
  input wire logic host_rd_b_i,
  input wire logic [lgcp_pkg::ADDR_W-1:0] host_addr_i,
  input wire logic [lgcp_pkg::DATA_W-1:0] host_data_i,
  output logic [lgcp_pkg::DATA_W-1:0] host_data_o,
  output logic host_data_oe_o,
  input wire logic arb_mode_i,
  input wire logic seg_tick_i,
  output logic [NCH-1:0] seg8_sign_o,
  output logic [NCH*(lgcp_pkg::AMP_W-1)-1:0] seg8_mag_o,
  input wire logic [NCH-1:0] channel_transmit_clock_i,
  input wire logic [NCH-1:0] transmit_positive_data_i,
  input wire logic [NCH-1:0] transmit_negative_data_i,
  input wire logic [NCH-1:0] receive_signal_loss_i,
  output logic [NCH-1:0] tx_pos_o,
  output logic [NCH-1:0] tx_neg_o,
  input wire logic [NCH-1:0] rx_clk_i,
  input wire logic [NCH-1:0] rx_data_i,
  output logic [NCH-1:0] rx_data_o,
  input wire logic [NCH-1:0] chan_irq_req_i,
  output logic [NCH-1:0] chan_irq_o,
  output logic single_rail_o,
  output logic soft_reset_o,
  output logic soft_reset_long_o
);
  import lgcp_pkg::*;

  logic [AMP_W-1:0] seg_amp_reg [NCH];
  logic [DATA_W-1:0] glob_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [SEG_W-1:0] seg_cnt_reg;
  logic [SRST_CNT_W-1:0] srst_cnt_reg;
  logic wr_en;
  logic rd_en;
  logic int_rst;
  logic is_seg8;
  logic [1:0] ch_sel;

  assign wr_en = !host_cs_b_i && !host_wr_b_i;
  assign rd_en = !host_cs_b_i && !host_rd_b_i;
  assign is_seg8 = host_addr_i[3:0] == SEG8_LOW_NIBBLE &&
                   host_addr_i[ADDR_W-1] == 1'b0;
  assign ch_sel = host_addr_i[5:4];
  assign int_rst = glob_reg[SRST_BIT];
  assign host_data_oe_o = rd_en;
  assign host_data_o = rdata_reg;
  assign single_rail_o = glob_reg[RAIL_BIT];
  assign soft_reset_o = int_rst;

  // host registers only see the pin reset, never the soft one
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      glob_reg <= GLOBAL_RESET;
    end else if (wr_en && host_addr_i == GLOBAL_CTRL_OFS) begin
      glob_reg <= host_data_i & ~(8'h01 << RSVD_BIT);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic tclk_q;
      logic rclk_q;
      logic tx_edge;
      logic rx_edge;
      logic ones_phase;
      logic auto_ones;

      // bit7 is not stored, so it reads zero and steers nothing
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          seg_amp_reg[g] <= SEG8_RESET;
        end else if (wr_en && is_seg8 && ch_sel == 2'(g)) begin
          seg_amp_reg[g] <= host_data_i[AMP_W-1:0];
        end
      end

      // sign-magnitude kept as is; the analog driver uses it directly
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          seg8_sign_o[g] <= 1'b0;
          seg8_mag_o[g*(AMP_W-1) +: AMP_W-1] <= '0;
        end else if (!int_rst && arb_mode_i && seg_cnt_reg == SEG8_INDEX) begin
          seg8_sign_o[g] <= seg_amp_reg[g][AMP_SIGN_BIT];
          seg8_mag_o[g*(AMP_W-1) +: AMP_W-1] <=
            seg_amp_reg[g][AMP_SIGN_BIT-1:0];
        end else begin
          seg8_sign_o[g] <= 1'b0;
          seg8_mag_o[g*(AMP_W-1) +: AMP_W-1] <= '0;
        end
      end

      assign tx_edge = glob_reg[TX_EDGE_BIT] ?
                       (channel_transmit_clock_i[g] && !tclk_q) :
                       (!channel_transmit_clock_i[g] && tclk_q);
      assign rx_edge = glob_reg[RX_EDGE_BIT] ?
                       (!rx_clk_i[g] && rclk_q) :
                       (rx_clk_i[g] && !rclk_q);
      assign auto_ones = glob_reg[AUTO_ONES_BIT] &&
                         receive_signal_loss_i[g];

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          tclk_q <= 1'b0;
          rclk_q <= 1'b0;
        end else begin
          tclk_q <= channel_transmit_clock_i[g];
          rclk_q <= rx_clk_i[g];
        end
      end

      // in dual rail, all-ones must alternate rails to stay bipolar
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          tx_pos_o[g] <= 1'b0;
          tx_neg_o[g] <= 1'b0;
          ones_phase <= 1'b0;
        end else if (int_rst) begin
          tx_pos_o[g] <= 1'b0;
          tx_neg_o[g] <= 1'b0;
          ones_phase <= 1'b0;
        end else if (tx_edge) begin
          if (auto_ones) begin
            tx_pos_o[g] <= single_rail_o || !ones_phase;
            tx_neg_o[g] <= !single_rail_o && ones_phase;
            ones_phase <= !ones_phase;
          end else begin
            tx_pos_o[g] <= transmit_positive_data_i[g] ^
                           glob_reg[POL_BIT];
            tx_neg_o[g] <= transmit_negative_data_i[g] ^ glob_reg[POL_BIT];
          end
        end
      end

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          rx_data_o[g] <= 1'b0;
        end else if (int_rst) begin
          rx_data_o[g] <= 1'b0;
        end else if (rx_edge) begin
          rx_data_o[g] <= rx_data_i[g] ^ glob_reg[POL_BIT];
        end
      end

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          chan_irq_o[g] <= 1'b0;
        end else begin
          chan_irq_o[g] <= chan_irq_req_i[g] && glob_reg[IRQ_EN_BIT] &&
                           !int_rst;
        end
      end
    end
  endgenerate

  // eight ticks make one master clock period
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seg_cnt_reg <= '0;
    end else if (int_rst || !arb_mode_i) begin
      seg_cnt_reg <= '0;
    end else if (seg_tick_i) begin
      seg_cnt_reg <= seg_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      srst_cnt_reg <= '0;
      soft_reset_long_o <= 1'b0;
    end else if (!int_rst) begin
      srst_cnt_reg <= '0;
      soft_reset_long_o <= 1'b0;
    end else if (srst_cnt_reg < SRST_CNT_W'(SRST_CYC)) begin
      srst_cnt_reg <= srst_cnt_reg + 12'h001;
    end else begin
      soft_reset_long_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= '0;
    end else if (rd_en) begin
      if (host_addr_i == GLOBAL_CTRL_OFS) begin
        rdata_reg <= glob_reg;
      end else if (is_seg8) begin
        rdata_reg <= {1'b0, seg_amp_reg[ch_sel]};
      end else begin
        rdata_reg <= '0;
      end
    end
  end

  sequence s_srst_set;
    !int_rst ##1 int_rst;
  endsequence

  sequence s_seg8_slot;
    arb_mode_i && !int_rst && seg_cnt_reg == SEG8_INDEX;
  endsequence

  AST_SEG8_DRIVE: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) s_seg8_slot |=>
    seg8_sign_o[0] == $past(seg_amp_reg[0][AMP_SIGN_BIT]) &&
    seg8_mag_o[AMP_W-2:0] == $past(seg_amp_reg[0][AMP_W-2:0]))
    else $error("segment 8 amplitude not driven");
  AST_SEG_OTHER_ZERO: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    !(arb_mode_i && !int_rst && seg_cnt_reg == SEG8_INDEX) |=>
    seg8_sign_o == '0 && seg8_mag_o == '0)
    else $error("sign driven outside segment 8");
  AST_IRQ_GATE: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) !glob_reg[IRQ_EN_BIT] |=> chan_irq_o == '0)
    else $error("interrupt passed while disabled");
  AST_SRST_HOLD: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) int_rst |=> tx_pos_o == '0 && rx_data_o == '0)
    else $error("datapath not held in soft reset");
  AST_REG_KEEP: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) s_srst_set |=> seg_amp_reg[0] == $past(seg_amp_reg[0])
    || $past(wr_en)) else $error("register lost on soft reset");
  AST_SRST_LONG: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) int_rst && srst_cnt_reg == 12'h000 |->
    !soft_reset_long_o [*8]) else $error("soft reset flagged too early");
  AST_AUTO_ONES: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) !int_rst && g_ch[0].tx_edge && g_ch[0].auto_ones
    && single_rail_o |=> tx_pos_o[0]) else $error("all ones not sent");
  AST_TX_POL: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) !int_rst && g_ch[0].tx_edge && !g_ch[0].auto_ones
    |=> tx_pos_o[0] == ($past(transmit_positive_data_i[0]) ^
    $past(glob_reg[POL_BIT]))) else $error("transmit polarity wrong");
  AST_RX_EDGE: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) !int_rst && glob_reg[RX_EDGE_BIT] &&
    $rose(rx_clk_i[0]) |=> $stable(rx_data_o[0]))
    else $error("receive data moved on wrong edge");
  AST_RSVD_ZERO: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) rd_en |=> !host_data_o[7] ||
    $past(host_addr_i) == GLOBAL_CTRL_OFS) else $error("reserved bit read one");
endmodule
